// file: inc/sps_pkg.sv
package sps_pkg;
  localparam int unsigned PAGE_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_ACTIVE = 8'h84;
  localparam logic [7:0] ADDR_MIDDLE = 8'h85;
  localparam logic [7:0] ADDR_BOTTOM = 8'h86;
  localparam logic [7:0] ADDR_CONTROL = 8'h96;
  localparam int unsigned AUTO_EN_BIT = 0;
  localparam logic [7:0] RST_ACTIVE = 8'h00;
  localparam logic [7:0] RST_MIDDLE = 8'h00;
  localparam logic [7:0] RST_BOTTOM = 8'h00;
  localparam logic RST_AUTO_EN = 1'b1;
  localparam logic [7:0] EMPTY_PAGE = 8'h00;
  localparam int unsigned N_GLOBAL = 8;
  localparam logic [N_GLOBAL*8-1:0] GLOBAL_ADDRS = 64'h8081_8284_8586_8790;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sps_sfr_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } sps_sfr_rsp_t;

  typedef struct packed {
    logic [7:0] active;
    logic [7:0] middle;
    logic [7:0] bottom;
    logic auto_en;
  } sps_state_t;
endpackage

// file: rtl/sps_global_decode.sv
`timescale 1ns/100ps
`default_nettype none
module sps_global_decode
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] active_page_select,
  output logic all_pages_q,
  output logic [7:0] page_q
);
  logic hit;
  logic all_pages_d;
  logic [7:0] page_d;
  logic [sps_pkg::N_GLOBAL-1:0] match;

  genvar g;
  generate
    for (g = 0; g < sps_pkg::N_GLOBAL; g++)
    begin : g_m
      assign match[g] = (addr == sps_pkg::GLOBAL_ADDRS[g*8 +: 8]);
    end
  endgenerate

  always_comb
  begin
    hit = |match;
    all_pages_d = hit; // RULE_11
    page_d = hit ? 8'h00 : active_page_select; // RULE_11
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      all_pages_q <= 1'b0;
      page_q <= 8'h00;
    end
    else
    begin
      all_pages_q <= all_pages_d;
      page_q <= page_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/sps_page_stack.sv
// How it works
// RULE_01: Auto page switching is on after reset until software clears the enable.
// RULE_02: Interrupt entry saves active page to middle, loads the source page.
// RULE_03: Each push moves middle into bottom, discarding the old bottom.
// RULE_04: Return from interrupt moves middle to active and bottom to middle.
// RULE_05: An empty bottom byte reads 0x00 and pops 0x00 into middle.
// RULE_06: Pushes only on interrupt service, pops only on return.
// RULE_07: Software writes change only the written byte, never push or pop.
// RULE_08: Active page accepts software writes any time, effective immediately; the code drops a write that lands in a push or pop cycle.
// RULE_09: All three stack bytes are readable and writable by software.
// RULE_10: With enable cleared, no page switch, push or pop happens.
// RULE_11: Registers present on every page decode regardless of active page.
// RULE_12: A preempting interrupt pushes again, shifting both earlier pages down.
// RULE_13: A push in the same cycle as a stack write wins over the write.
`timescale 1ns/100ps
`default_nettype none
module sps_page_stack
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_enter,
  input wire logic [7:0] irq_page,
  input wire logic irq_return,
  input wire sps_pkg::sps_sfr_req_t sfr_req,
  output sps_pkg::sps_sfr_rsp_t sfr_rsp,
  output logic [7:0] active_page_select,
  output logic [7:0] page_stack_middle,
  output logic [7:0] page_stack_bottom,
  output logic auto_page_enable,
  output logic decode_all_pages,
  output logic [7:0] decode_page
);
  // Stack operation chosen for this cycle
  typedef enum logic [1:0] {OP_HOLD, OP_PUSH, OP_POP} sps_op_t;

  sps_pkg::sps_state_t st_q;
  sps_pkg::sps_state_t st_d;
  sps_pkg::sps_sfr_rsp_t rsp_q;
  sps_pkg::sps_sfr_rsp_t rsp_d;
  sps_op_t op;
  logic wr_act;
  logic wr_mid;
  logic wr_bot;
  logic wr_ctl;
  logic [7:0] rd_mux;

  // Entry beats a return seen in the same cycle
  always_comb
  begin
    op = OP_HOLD;
    if (st_q.auto_en)
    begin
      if (irq_enter)
      begin
        op = OP_PUSH; // RULE_06 RULE_10 RULE_12
      end
      else if (irq_return)
      begin
        op = OP_POP; // RULE_06 RULE_10
      end
    end
  end

  // One write strobe per byte, all low without a write
  always_comb
  begin
    wr_act = 1'b0;
    wr_mid = 1'b0;
    wr_bot = 1'b0;
    wr_ctl = 1'b0;
    if (sfr_req.we)
    begin
      unique case (sfr_req.addr)
        sps_pkg::ADDR_ACTIVE:
        begin
          wr_act = 1'b1; // RULE_08
        end
        sps_pkg::ADDR_MIDDLE:
        begin
          wr_mid = 1'b1; // RULE_09
        end
        sps_pkg::ADDR_BOTTOM:
        begin
          wr_bot = 1'b1; // RULE_09
        end
        sps_pkg::ADDR_CONTROL:
        begin
          wr_ctl = 1'b1; // RULE_01
        end
        default:
        begin
          wr_act = 1'b0;
        end
      endcase
    end
  end

  // Enable write lands even in a push cycle; the push used the old enable
  always_comb
  begin
    st_d = st_q;
    if (wr_ctl)
    begin
      st_d.auto_en = sfr_req.wdata[sps_pkg::AUTO_EN_BIT]; // RULE_01
    end
    unique case (op)
      OP_PUSH:
      begin
        st_d.middle = st_q.active; // RULE_02 RULE_13
        st_d.bottom = st_q.middle; // RULE_03 RULE_12 RULE_13
        st_d.active = irq_page; // RULE_02
      end
      OP_POP:
      begin
        st_d.active = st_q.middle; // RULE_04
        st_d.middle = st_q.bottom; // RULE_04 RULE_05
        st_d.bottom = sps_pkg::EMPTY_PAGE; // RULE_05
      end
      OP_HOLD:
      begin
        // Byte writes touch only their own byte
        if (wr_act)
        begin
          st_d.active = sfr_req.wdata; // RULE_07 RULE_08
        end
        if (wr_mid)
        begin
          st_d.middle = sfr_req.wdata; // RULE_07 RULE_09
        end
        if (wr_bot)
        begin
          st_d.bottom = sfr_req.wdata; // RULE_07 RULE_09
        end
      end
    endcase
  end

  // Read selection by address
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (sfr_req.addr)
      sps_pkg::ADDR_ACTIVE:
      begin
        rd_mux = st_q.active; // RULE_08
      end
      sps_pkg::ADDR_MIDDLE:
      begin
        rd_mux = st_q.middle; // RULE_09
      end
      sps_pkg::ADDR_BOTTOM:
      begin
        rd_mux = st_q.bottom; // RULE_09
      end
      sps_pkg::ADDR_CONTROL:
      begin
        rd_mux = {7'h00, st_q.auto_en};
      end
      default:
      begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Idle cycles return zero so stale bytes never leak
  always_comb
  begin
    rsp_d.rvalid = sfr_req.re;
    rsp_d.rdata = 8'h00;
    if (sfr_req.re)
    begin
      rsp_d.rdata = rd_mux;
    end
  end

  // Reset leaves the stack empty with auto switching on
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q.active <= sps_pkg::RST_ACTIVE;
      st_q.middle <= sps_pkg::RST_MIDDLE;
      st_q.bottom <= sps_pkg::RST_BOTTOM;
      st_q.auto_en <= sps_pkg::RST_AUTO_EN; // RULE_01
    end
    else
    begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rsp_q <= '0;
    end
    else
    begin
      rsp_q <= rsp_d;
    end
  end

  assign sfr_rsp = rsp_q;
  assign active_page_select = st_q.active;
  assign page_stack_middle = st_q.middle;
  assign page_stack_bottom = st_q.bottom;
  assign auto_page_enable = st_q.auto_en;

  sps_global_decode u_dec
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .addr(sfr_req.addr),
    .active_page_select(st_d.active),
    .all_pages_q(decode_all_pages),
    .page_q(decode_page)
  );
endmodule
`default_nettype wire

// file: sim/sps_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module sps_core_model
(
  input wire logic mclk,
  output logic irq_enter,
  output logic [7:0] irq_page,
  output logic irq_return
);
  initial {irq_enter, irq_return, irq_page} = '0;
  // One vectoring or return pulse
  task automatic ev(input logic e, input logic [7:0] g);
    @(posedge mclk);
    {irq_enter, irq_return, irq_page} <= {e, !e, g};
    @(posedge mclk);
    {irq_enter, irq_return, irq_page} <= {2'h0, ~g};
  endtask
endmodule
`default_nettype wire

// file: sim/sps_page_stack_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sps_page_stack_sva
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic irq_enter,
  input wire logic [7:0] irq_page,
  input wire logic irq_return,
  input wire sps_pkg::sps_sfr_req_t sfr_req,
  input wire logic [7:0] active_page_select,
  input wire logic [7:0] page_stack_middle,
  input wire logic [7:0] page_stack_bottom,
  input wire logic auto_page_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire [7:0] a = active_page_select;
  wire [7:0] m = page_stack_middle;
  wire [7:0] b = page_stack_bottom;
  wire p = irq_enter && auto_page_enable;
  wire r = irq_return && !irq_enter && auto_page_enable;
  a_reset_on: assert property (!$past(rst_n) |-> auto_page_enable) else $error("enable");
  a_push_load: assert property (p |=> a == $past(irq_page)) else $error("load");
  a_push_save: assert property (p |=> m == $past(a)) else $error("save");
  a_push_shift: assert property (p |=> b == $past(m)) else $error("shift");
  a_pop_restore: assert property (r |=> a == $past(m) && m == $past(b)) else $error("pop");
  a_pop_empty: assert property (r |=> b == 8'h00) else $error("empty");
  a_idle_hold: assert property (!irq_enter && !irq_return && !sfr_req.we |=> $stable({a, m, b}))
    else $error("idle");
  a_off_hold: assert property (!auto_page_enable && !sfr_req.we |=> $stable({a, m, b}))
    else $error("off");
  cover property (p && sfr_req.we);
  cover property (r);
  cover property (irq_enter && !auto_page_enable);
endmodule
bind sps_page_stack sps_page_stack_sva u_sps_page_stack_sva (.*);
`default_nettype wire

// file: sim/test_sps_page_stack.sv
`timescale 1ns/100ps
`default_nettype none
module test_sps_page_stack;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic irq_enter, irq_return, auto_page_enable, decode_all_pages;
  logic [7:0] irq_page, active_page_select, page_stack_middle, page_stack_bottom, decode_page;
  sps_pkg::sps_sfr_req_t sfr_req = '0;
  sps_pkg::sps_sfr_rsp_t sfr_rsp;
  int failures = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  sps_page_stack u_sps_page_stack (.*);
  sps_core_model u_sps_core_model (.*);
  task automatic chk(input logic [23:0] g, e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, d);
    @(posedge mclk);
    sfr_req <= '{w, !w, ad, d};
    @(posedge mclk);
    sfr_req <= '0;
    #1;
  endtask
  task automatic stk(input logic [23:0] e);
    #1;
    chk({active_page_select, page_stack_middle, page_stack_bottom}, e);
  endtask
  task automatic t_nest;
    acc(1'b1, 8'h84, 8'h0F);
    acc(1'b1, 8'h86, 8'h5A);
    u_sps_core_model.ev(1'b1, 8'h02);
    stk(24'h020F00);
    u_sps_core_model.ev(1'b1, 8'h00);
    stk(24'h00020F);
    u_sps_core_model.ev(1'b0, 8'h00);
    stk(24'h020F00);
  endtask
  task automatic t_edit;
    acc(1'b1, 8'h85, 8'h01);
    stk(24'h020100);
    fork
      u_sps_core_model.ev(1'b1, 8'h04);
      acc(1'b1, 8'h85, 8'h77);
    join
    stk(24'h040201);
  endtask
  task automatic t_off;
    acc(1'b1, 8'h96, 8'h00);
    u_sps_core_model.ev(1'b1, 8'h06);
    stk(24'h040201);
    acc(1'b0, 8'h84, 8'h00);
    chk({7'h0, sfr_rsp.rvalid, sfr_rsp.rdata, 7'h0, decode_all_pages}, 24'h010401);
    chk({16'h0, decode_page}, 24'h000000);
    acc(1'b0, 8'h96, 8'h00);
    chk({sfr_rsp.rdata, decode_page, 7'h0, decode_all_pages}, 24'h000400);
  endtask
  task automatic t_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    stk(24'h000000);
    chk({23'h0, auto_page_enable}, 24'h000001);
    u_sps_core_model.ev(1'b1, 8'h03);
    stk(24'h030000);
  endtask
  task automatic finish_test;
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    stk(24'h000000);
    chk({23'h0, auto_page_enable}, 24'h000001);
    t_nest;
    t_edit;
    t_off;
    t_reset;
    finish_test;
  end
  initial
  begin
    #9000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire
